//--- rtl/lao_pkg.sv
// Constants for the loop alarm conditioner: register map, fields, limits.
// Assumes a 100 MHz system clock.
package lao_pkg;
  // Timing
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 1000000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int TICK_W = 27;
  // Register offsets
  localparam logic [7:0] A_LOOP = 8'h00;
  localparam logic [7:0] A_GRP = 8'h01;
  localparam logic [7:0] A_STAT = 8'h02;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_HYS = 8'h08;
  localparam logic [7:0] A_DLY = 8'h10;
  localparam logic [7:0] A_AV = 8'h20;
  // Level configuration fields
  localparam int CFG_EN = 0;
  localparam int CFG_SB = 1;
  localparam int CFG_TY = 2;
  localparam int CFG_ACT = 5;
  // Delay word fields
  localparam int DLY_MIN = 0;
  localparam int DLY_SEC = 8;
  // Limits and reset values
  localparam logic [15:0] LOOP_MIN = 16'h0001;
  localparam logic [15:0] LOOP_MAX = 16'h028c;
  localparam logic [9:0] LOOP_RST = 10'h001;
  localparam logic [15:0] GRP_MIN = 16'h0001;
  localparam logic [15:0] GRP_MAX = 16'h0008;
  localparam logic [3:0] GRP_RST = 4'h1;
  localparam logic signed [15:0] AV_MIN = -16'sd30000;
  localparam logic signed [15:0] AV_MAX = 16'sd30000;
  localparam logic [15:0] HYS_MAX = 16'h7530;
  localparam logic [6:0] MIN_MAX = 7'h63;
  localparam logic [5:0] SEC_MAX = 6'h3b;
  localparam logic [12:0] SEC_PER_MIN = 13'h003c;
  localparam logic [9:0] CFG_RST = 10'h020;
  // Comparison types: bit 0 low side, bits 2:1 source
  localparam logic [2:0] TY_PVH = 3'h0;
  localparam logic [2:0] TY_PVL = 3'h1;
  localparam logic [2:0] TY_SPH = 3'h2;
  localparam logic [2:0] TY_SPL = 3'h3;
  localparam logic [2:0] TY_OTH = 3'h4;
  localparam logic [2:0] TY_OTL = 3'h5;
  // Relay actions
  typedef enum logic [4:0] {
    ACT_NONHOLD = 5'h01,
    ACT_HOLD = 5'h02,
    ACT_HOLD_RST = 5'h04,
    ACT_NH_RST = 5'h08,
    ACT_HOLD_NORM = 5'h10
  } lao_act_t;
endpackage : lao_pkg

//--- rtl/lao_level.sv
// One alarm level: delay timers and relay hold behaviour.
// Assumes the condition is already compared, filtered and suppressed.
`timescale 1ns/1ns
`default_nettype none
module lao_level (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Level settings
  input wire logic en_in,
  input wire logic [4:0] act_in,
  input wire logic [12:0] on_secs_in,
  input wire logic [12:0] off_secs_in,
  // Events
  input wire logic cond_in,
  input wire logic tick_in,
  input wire logic ack_in,
  input wire logic period_in,
  // Results
  output logic status_out,
  output logic relay_out
);
  logic alm_reg, alm_next, latch_reg, latch_next;
  logic mute_reg, mute_next, relay_reg, relay_next;
  logic [12:0] cnt_reg, cnt_next, lim;
  logic rise, held;

  always_comb begin
    alm_next = alm_reg;
    cnt_next = cnt_reg;
    latch_next = latch_reg;
    mute_next = mute_reg;
    held = 1'b1;
    lim = cond_in ? on_secs_in : off_secs_in;
    if (cond_in == alm_reg) begin
      cnt_next = '0; // R11 R14
    end else if (lim == '0) begin
      alm_next = cond_in; // R21
    end else if (tick_in) begin
      if (cnt_reg + 13'h1 >= lim) begin
        alm_next = cond_in; // R10 R13
        cnt_next = '0;
      end else begin
        cnt_next = cnt_reg + 13'h1; // R12
      end
    end
    rise = alm_next && !alm_reg;
    case (act_in)
      lao_pkg::ACT_HOLD: begin
        if (alm_next) latch_next = 1'b1; // R16 R18
        else if (ack_in) latch_next = 1'b0;
      end
      lao_pkg::ACT_HOLD_RST: begin
        if (rise) latch_next = 1'b1; // R16
        else if (ack_in) latch_next = 1'b0;
      end
      lao_pkg::ACT_NH_RST: begin
        if (rise) latch_next = 1'b1;
        else if (ack_in || !alm_next) latch_next = 1'b0; // R19
      end
      lao_pkg::ACT_HOLD_NORM: begin
        if (period_in) mute_next = 1'b0;
        if (ack_in) begin
          latch_next = 1'b0; // R20
          mute_next = alm_next;
        end else if (alm_next && !mute_reg) begin
          latch_next = 1'b1;
        end
      end
      default: begin
        // Nonhold and unknown codes follow the alarm directly
        held = 1'b0;
        latch_next = 1'b0;
        mute_next = 1'b0;
      end
    endcase
    relay_next = held ? latch_next : alm_next; // R15
    if (!en_in) begin
      alm_next = 1'b0; // R1
      cnt_next = '0;
      latch_next = 1'b0;
      mute_next = 1'b0;
      relay_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      alm_reg <= 1'b0;
      cnt_reg <= '0;
      latch_reg <= 1'b0;
      mute_reg <= 1'b0;
      relay_reg <= 1'b0;
    end else begin
      alm_reg <= alm_next;
      cnt_reg <= cnt_next;
      latch_reg <= latch_next;
      mute_reg <= mute_next;
      relay_reg <= relay_next;
    end
  end

  assign status_out = alm_reg;
  assign relay_out = relay_reg;
endmodule : lao_level
`default_nettype wire

//--- rtl/lao_top.sv
// Loop alarm conditioner: four alarm levels of one control loop.
// Assumes same-clock process values and a plain register port.
// Overview of operation
// R1: Per-level enable, default off, blocks output.
// R2: Loop id spans 1 to 652.
// R3: Signed alarm value per level and group.
// R4: Active group selects alarm values, 1 to 8.
// R5: Stand-by suppresses until condition first false.
// R6: Stand-by arms at reset, SP, type change.
// R7: Group change arms only if SP changes.
// R8: Remote SP changes never arm stand-by.
// R9: Unsigned hysteresis per level, 0 to 30000.
// R10: On-delay timer gates alarm assertion.
// R11: Condition false clears running on-delay.
// R12: Status and output hold while timing.
// R13: Off-delay timer gates alarm release.
// R14: Condition true clears running off-delay.
// R15: Five relay actions, nonhold by default.
// R16: Hold actions latch until acknowledge.
// R17: High type: set at value, release below hysteresis.
// R18: Plain hold ignores acknowledge while alarm true.
// R19: Nonhold reset: off on ack or clear.
// R20: Normal-on-ack mutes for one control period.
// R21: Timers count seconds; zero acts immediately.
`timescale 1ns/1ns
`default_nettype none
module lao_top #(
  parameter int TICK_CYC = lao_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // Process values
  input wire logic [15:0] pv_in,
  input wire logic [15:0] sp_in,
  input wire logic [15:0] mv_in,
  input wire logic remote_in,
  input wire logic period_in,
  // Acknowledge
  input wire logic ack_op_in,
  input wire logic ack_pin_in,
  // Alarm results
  output logic [3:0] status_out,
  output logic [3:0] relay_out,
  output logic [9:0] loop_id_out
);

  ////////////////////////////////////////////////////////////////////////
  // Settings registers

  logic [9:0] loop_reg, loop_next;
  logic [3:0] grp_reg, grp_next;
  logic [9:0] cfg_reg [4];
  logic [9:0] cfg_next [4];
  logic [14:0] hys_reg [4];
  logic [14:0] hys_next [4];
  logic [15:0] dly_reg [8];
  logic [15:0] dly_next [8];
  logic [15:0] av_reg [32];
  logic [15:0] av_next [32];
  logic [15:0] rdata_reg, rdata_next;
  logic [3:0] tychg;
  logic [3:0] sb_reg, sb_next;
  logic [3:0] status_w, relay_w;

  always_comb begin
    loop_next = loop_reg;
    grp_next = grp_reg;
    for (int i = 0; i < 4; i++) begin
      cfg_next[i] = cfg_reg[i];
      hys_next[i] = hys_reg[i];
    end
    for (int i = 0; i < 8; i++) dly_next[i] = dly_reg[i];
    for (int i = 0; i < 32; i++) av_next[i] = av_reg[i];
    tychg = '0;
    rdata_next = '0;
    if (wr_in) begin
      if (addr_in == lao_pkg::A_LOOP && wdata_in >= lao_pkg::LOOP_MIN
          && wdata_in <= lao_pkg::LOOP_MAX) begin
        loop_next = wdata_in[9:0]; // R2
      end
      if (addr_in == lao_pkg::A_GRP && wdata_in >= lao_pkg::GRP_MIN
          && wdata_in <= lao_pkg::GRP_MAX) begin
        grp_next = wdata_in[3:0]; // R4
      end
      if (addr_in[7:2] == lao_pkg::A_CFG[7:2]) begin
        cfg_next[addr_in[1:0]] = wdata_in[9:0];
        tychg[addr_in[1:0]] = wdata_in[lao_pkg::CFG_TY +: 3]
          != cfg_reg[addr_in[1:0]][lao_pkg::CFG_TY +: 3]; // R6
      end
      if (addr_in[7:2] == lao_pkg::A_HYS[7:2] && wdata_in <= lao_pkg::HYS_MAX) begin
        hys_next[addr_in[1:0]] = wdata_in[14:0]; // R9
      end
      if (addr_in[7:3] == lao_pkg::A_DLY[7:3]
          && wdata_in[lao_pkg::DLY_MIN +: 7] <= lao_pkg::MIN_MAX
          && wdata_in[lao_pkg::DLY_SEC +: 6] <= lao_pkg::SEC_MAX) begin
        dly_next[addr_in[2:0]] = wdata_in; // R10 R13
      end
      if (addr_in[7:5] == lao_pkg::A_AV[7:5]
          && $signed(wdata_in) >= lao_pkg::AV_MIN
          && $signed(wdata_in) <= lao_pkg::AV_MAX) begin
        av_next[addr_in[4:0]] = wdata_in; // R3
      end
    end
    if (rd_in) begin
      if (addr_in == lao_pkg::A_LOOP) rdata_next = {6'h00, loop_reg};
      else if (addr_in == lao_pkg::A_GRP) rdata_next = {12'h000, grp_reg};
      else if (addr_in == lao_pkg::A_STAT) rdata_next = {4'h0, sb_reg, relay_w, status_w};
      else if (addr_in[7:2] == lao_pkg::A_CFG[7:2]) rdata_next = {6'h00, cfg_reg[addr_in[1:0]]};
      else if (addr_in[7:2] == lao_pkg::A_HYS[7:2]) rdata_next = {1'b0, hys_reg[addr_in[1:0]]};
      else if (addr_in[7:3] == lao_pkg::A_DLY[7:3]) rdata_next = dly_reg[addr_in[2:0]];
      else if (addr_in[7:5] == lao_pkg::A_AV[7:5]) rdata_next = av_reg[addr_in[4:0]];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      loop_reg <= lao_pkg::LOOP_RST;
      grp_reg <= lao_pkg::GRP_RST;
      for (int i = 0; i < 4; i++) begin
        cfg_reg[i] <= lao_pkg::CFG_RST; // R1 R15
        hys_reg[i] <= '0;
      end
      for (int i = 0; i < 8; i++) dly_reg[i] <= '0;
      for (int i = 0; i < 32; i++) av_reg[i] <= '0;
      rdata_reg <= '0;
    end else begin
      loop_reg <= loop_next;
      grp_reg <= grp_next;
      for (int i = 0; i < 4; i++) begin
        cfg_reg[i] <= cfg_next[i];
        hys_reg[i] <= hys_next[i];
      end
      for (int i = 0; i < 8; i++) dly_reg[i] <= dly_next[i];
      for (int i = 0; i < 32; i++) av_reg[i] <= av_next[i];
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One-second tick

  logic [lao_pkg::TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
  logic tick_reg, tick_next;

  always_comb begin
    tick_next = tick_cnt_reg == lao_pkg::TICK_W'(TICK_CYC - 1); // R21
    tick_cnt_next = tick_next ? '0 : tick_cnt_reg + 1'b1;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Acknowledge from operator or contact

  logic ack_s1_reg, ack_s2_reg, ack_s3_reg, ack_lvl_reg, ack_lvl_next;
  logic ack_w;

  always_comb begin
    // Contact counts only once the last two stages agree
    ack_lvl_next = (ack_s2_reg == ack_s3_reg) ? ack_s2_reg : ack_lvl_reg;
    ack_w = ack_op_in | (ack_lvl_next & ~ack_lvl_reg); // R16
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_s3_reg <= 1'b0;
      ack_lvl_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_pin_in;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
      ack_lvl_reg <= ack_lvl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparison, hysteresis and stand-by

  logic [15:0] sp_q_reg;
  logic [3:0] hcond_reg, hcond_next, arm, lvl_cond;
  logic [15:0] av_sel [4];
  logic [12:0] secs [8];
  logic [3:0] gm1;
  logic [2:0] ty;
  logic [15:0] src;
  logic signed [17:0] v, a, h;
  logic hit, rel, arm_sp;

  always_comb begin
    // Remote setpoint moves never arm; a group switch arms only via SP
    arm_sp = (sp_in != sp_q_reg) && !remote_in; // R6 R7 R8
    gm1 = grp_reg - 4'h1;
    ty = '0;
    src = '0;
    v = '0;
    a = '0;
    h = '0;
    hit = 1'b0;
    rel = 1'b0;
    for (int i = 0; i < 4; i++) begin
      av_sel[i] = av_reg[{gm1[2:0], 2'(i)}]; // R4
      ty = cfg_reg[i][lao_pkg::CFG_TY +: 3];
      case (ty[2:1])
        2'h0: src = pv_in;
        2'h1: src = sp_in;
        default: src = mv_in;
      endcase
      // Widened so value plus hysteresis cannot wrap
      v = {{2{src[15]}}, src};
      a = {{2{av_sel[i][15]}}, av_sel[i]};
      h = {3'h0, hys_reg[i]};
      if (ty[0]) begin
        hit = v <= a;
        rel = v > a + h;
      end else begin
        hit = v >= a; // R17
        rel = v < a - h;
      end
      hcond_next[i] = hcond_reg[i] ? !rel : hit; // R9
      arm[i] = arm_sp | tychg[i];
      sb_next[i] = arm[i] | (sb_reg[i] & hcond_next[i]); // R5
      lvl_cond[i] = cfg_reg[i][lao_pkg::CFG_EN] & hcond_reg[i]
        & ~(cfg_reg[i][lao_pkg::CFG_SB] & sb_reg[i]); // R1 R5
    end
    for (int i = 0; i < 8; i++) begin
      secs[i] = 13'(dly_reg[i][lao_pkg::DLY_MIN +: 7]) * lao_pkg::SEC_PER_MIN
        + 13'(dly_reg[i][lao_pkg::DLY_SEC +: 6]); // R21
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sp_q_reg <= '0;
      hcond_reg <= '0;
      sb_reg <= '1; // R6
    end else begin
      sp_q_reg <= sp_in;
      hcond_reg <= hcond_next;
      sb_reg <= sb_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Levels

  for (genvar g = 0; g < 4; g++) begin : g_lvl
    lao_level u_lvl (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .en_in(cfg_reg[g][lao_pkg::CFG_EN]),
      .act_in(cfg_reg[g][lao_pkg::CFG_ACT +: 5]),
      .on_secs_in(secs[g]),
      .off_secs_in(secs[g + 4]),
      .cond_in(lvl_cond[g]),
      .tick_in(tick_reg),
      .ack_in(ack_w),
      .period_in(period_in),
      .status_out(status_w[g]),
      .relay_out(relay_w[g])
    );
  end

  assign rdata_out = rdata_reg;
  assign status_out = status_w;
  assign relay_out = relay_w;
  assign loop_id_out = loop_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks on level 0 and on the loop id and group settings

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  property p_dis;
    !cfg_reg[0][lao_pkg::CFG_EN] |=> !status_w[0] && !relay_w[0];
  endproperty
  a_dis: assert property (p_dis) else $error("disabled level active"); // R1

  property p_loop;
    loop_reg != 10'h000 && {6'h00, loop_reg} <= lao_pkg::LOOP_MAX;
  endproperty
  a_loop: assert property (p_loop) else $error("loop id out of range"); // R2

  property p_avrng;
    wr_in && addr_in == lao_pkg::A_AV && $signed(wdata_in) > lao_pkg::AV_MAX
      |=> $stable(av_reg[0]);
  endproperty
  a_avrng: assert property (p_avrng) else $error("alarm value overrange stored"); // R3

  property p_grp;
    grp_reg >= 4'h1 && grp_reg <= 4'h8;
  endproperty
  a_grp: assert property (p_grp) else $error("group out of range"); // R4

  property p_sbclr;
    sb_reg[0] && !hcond_next[0] && !arm[0] |=> !sb_reg[0];
  endproperty
  a_sbclr: assert property (p_sbclr) else $error("stand-by not cleared"); // R5

  property p_remote;
    remote_in && !tychg[0] && !sb_reg[0] |=> !sb_reg[0];
  endproperty
  a_remote: assert property (p_remote) else $error("remote change armed stand-by"); // R8

  property p_hyst;
    {1'b0, hys_reg[0]} <= lao_pkg::HYS_MAX;
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis out of range"); // R9

  property p_high;
    cfg_reg[0][lao_pkg::CFG_TY +: 3] == lao_pkg::TY_PVH
      && $signed(pv_in) >= $signed(av_sel[0]) |=> hcond_reg[0];
  endproperty
  a_high: assert property (p_high) else $error("high compare missed"); // R17

  property p_zero;
    lvl_cond[0] && !status_w[0] && secs[0] == 13'h0000 |=> status_w[0];
  endproperty
  a_zero: assert property (p_zero) else $error("zero on-delay not immediate"); // R21

  property p_hold;
    cfg_reg[0][lao_pkg::CFG_ACT +: 5] == lao_pkg::ACT_HOLD && cfg_reg[0][lao_pkg::CFG_EN]
      && ack_w && lvl_cond[0] && status_w[0] && relay_w[0] |=> relay_w[0];
  endproperty
  a_hold: assert property (p_hold) else $error("hold released while alarm true"); // R18

  c_sbclr: cover property (sb_reg[0] ##1 !sb_reg[0]);
  c_ack: cover property (ack_w && relay_w[0] ##1 !relay_w[0]);
  c_delay: cover property (tick_reg && !status_w[0] ##1 status_w[0]);
endmodule : lao_top
`default_nettype wire

//--- verif/lao_tb.sv
// Self-checking bench for the loop alarm conditioner top.
// Assumes a ten-cycle tick and the register map of the package.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int TK = 10;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] pv_in = 16'h0000;
  logic [15:0] sp_in = 16'h0000;
  logic [15:0] mv_in = 16'h0000;
  logic remote_in = 1'b0;
  logic period_in = 1'b0;
  logic ack_op_in = 1'b0;
  logic ack_pin_in = 1'b0;
  logic [15:0] rdata_out;
  logic [3:0] status_out;
  logic [3:0] relay_out;
  logic [9:0] loop_id_out;
  int error_cnt = 0;
  int compares = 0;

  lao_top #(.TICK_CYC(TK)) uut (
    .clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .pv_in(pv_in), .sp_in(sp_in),
    .mv_in(mv_in), .remote_in(remote_in), .period_in(period_in),
    .ack_op_in(ack_op_in), .ack_pin_in(ack_pin_in),
    .status_out(status_out), .relay_out(relay_out),
    .loop_id_out(loop_id_out)
  );

  always #5 clk_in = ~clk_in;

  ////////////////////////////////////////////////////////////
  task automatic close_out;
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Leaves us 1 ns past an edge so later drives stay off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] e,
                     input logic [15:0] m = 16'hffff);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(nm, rdata_out & m, e);
  endtask : rdc

  task automatic setpv(input logic [15:0] v, input int n);
    @(posedge clk_in);
    pv_in <= v;
    cyc(n);
  endtask : setpv

  task automatic st(input string nm, input logic e);
    chk(nm, {15'h0000, status_out[0]}, {15'h0000, e});
  endtask : st

  task automatic rl(input string nm, input logic e);
    chk(nm, {15'h0000, relay_out[0]}, {15'h0000, e});
  endtask : rl

  // Bounded wait; running out ends the run as a failure
  task automatic wst(input logic e);
    for (int n = 0; n < 50; n++) begin
      cyc(1);
      if (status_out[0] === e) return;
    end
    st("status wait", e);
    close_out();
  endtask : wst

  // Contact pin needs a few cycles of synchronising
  task automatic ack(input logic pin);
    @(posedge clk_in);
    if (pin) ack_pin_in <= 1'b1;
    else ack_op_in <= 1'b1;
    @(posedge clk_in);
    ack_op_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    ack_pin_in <= 1'b0;
    cyc(2);
  endtask : ack

  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("loop id pin", {6'h00, loop_id_out}, 16'h0001);
    rdc("loop id", 8'h00, 16'h0001);
    rdc("group", 8'h01, 16'h0001);
    rdc("status", 8'h02, 16'h0000, 16'h00ff);
    cyc(1);
    chk("rdata idle", rdata_out, 16'h0000);
    rdc("unmapped", 8'h0c, 16'h0000);
    for (int l = 0; l < 4; l++) begin
      rdc("cfg", 8'h04 + 8'(l), 16'h0020);
      rdc("hys", 8'h08 + 8'(l), 16'h0000);
      rdc("on dly", 8'h10 + 8'(l), 16'h0000);
      rdc("off dly", 8'h14 + 8'(l), 16'h0000);
    end
    for (int g = 0; g < 8; g++) begin
      rdc("alarm value", 8'h20 + 8'(4 * g), 16'h0000);
    end
  endtask : t_reset

  task automatic t_range;
    wr(8'h00, 16'h028c);
    wr(8'h00, 16'h028d);
    rdc("loop id max", 8'h00, 16'h028c);
    chk("loop id pin max", {6'h00, loop_id_out}, 16'h028c);
    wr(8'h00, 16'h0000);
    rdc("loop id zero", 8'h00, 16'h028c);
    wr(8'h01, 16'h0009);
    wr(8'h01, 16'h0000);
    rdc("group range", 8'h01, 16'h0001);
    wr(8'h08, 16'h7530);
    wr(8'h08, 16'h7531);
    rdc("hys max", 8'h08, 16'h7530);
    wr(8'h20, 16'h8ad0);
    wr(8'h20, 16'h8acf);
    wr(8'h20, 16'h7531);
    rdc("av min", 8'h20, 16'h8ad0);
    wr(8'h10, 16'h0064);
    wr(8'h10, 16'h3c00);
    rdc("dly range", 8'h10, 16'h0000);
    wr(8'h08, 16'h000a);
    wr(8'h20, 16'h0064);
  endtask : t_range

  // Alarm value 100, hysteresis 10, only level 1 on
  task automatic t_hys;
    wr(8'h04, 16'h0021);
    setpv(16'h0063, 3);
    st("below value", 1'b0);
    setpv(16'h0064, 3);
    chk("status", {12'h000, status_out}, 16'h0001);
    chk("relay", {12'h000, relay_out}, 16'h0001);
    setpv(16'h005a, 3);
    st("band edge", 1'b1);
    setpv(16'h0059, 3);
    st("below band", 1'b0);
  endtask : t_hys

  task automatic t_grp;
    wr(8'h24, 16'h00c8);
    rdc("av group 2", 8'h24, 16'h00c8);
    setpv(16'h0096, 3);
    st("group 1", 1'b1);
    wr(8'h01, 16'h0002);
    wst(1'b0);
    wr(8'h01, 16'h0001);
    wst(1'b1);
    setpv(16'h0032, 3);
  endtask : t_grp

  task automatic t_sb;
    wr(8'h04, 16'h0023);
    @(posedge clk_in);
    sp_in <= 16'h0010;
    setpv(16'h0096, 6);
    st("sp change", 1'b0);
    rl("sp change", 1'b0);
    rdc("stand-by word", 8'h02, 16'h0f00);
    setpv(16'h0032, 3);
    setpv(16'h0096, 0);
    wst(1'b1);
    setpv(16'h0032, 3);
    @(posedge clk_in);
    remote_in <= 1'b1;
    sp_in <= 16'h0020;
    setpv(16'h0096, 0);
    wst(1'b1);
    @(posedge clk_in);
    remote_in <= 1'b0;
    setpv(16'h0032, 3);
    wr(8'h04, 16'h0027);
    cyc(6);
    st("type change", 1'b0);
    wr(8'h04, 16'h0023);
    wr(8'h01, 16'h0002);
    setpv(16'h00c8, 0);
    wst(1'b1);
    wr(8'h01, 16'h0001);
    setpv(16'h0032, 3);
    wr(8'h04, 16'h0021);
  endtask : t_sb

  // Two-second timers; a tick is TK cycles
  task automatic t_dly;
    wr(8'h10, 16'h0200);
    setpv(16'h0096, 5);
    st("on dly running", 1'b0);
    wst(1'b1);
    setpv(16'h0032, 3);
    st("zero off dly", 1'b0);
    setpv(16'h0096, 3);
    setpv(16'h0032, 40);
    st("on dly cut", 1'b0);
    wr(8'h10, 16'h0000);
    wr(8'h14, 16'h0200);
    setpv(16'h0096, 3);
    st("zero on dly", 1'b1);
    setpv(16'h0032, 5);
    st("off dly running", 1'b1);
    rl("off dly running", 1'b1);
    wst(1'b0);
    setpv(16'h0096, 3);
    setpv(16'h0032, 3);
    setpv(16'h0096, 40);
    st("off dly cut", 1'b1);
    setpv(16'h0032, 0);
    wst(1'b0);
    wr(8'h14, 16'h0000);
  endtask : t_dly

  task automatic t_act;
    logic [4:0] a [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
    logic e1 [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic e2 [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 5; i++) begin
      wr(8'h04, {6'h00, a[i], 5'h01});
      setpv(16'h0096, 3);
      rl("relay on", 1'b1);
      ack(i == 2);
      rl("ack while true", e1[i]);
      st("status kept", 1'b1);
      if (i == 4) begin
        @(posedge clk_in);
        period_in <= 1'b1;
        @(posedge clk_in);
        period_in <= 1'b0;
        cyc(3);
        rl("after period", 1'b1);
      end
      setpv(16'h0032, 3);
      rl("condition gone", e2[i]);
      ack(1'b0);
      rl("released", 1'b0);
    end
    wr(8'h04, 16'h0021);
  endtask : t_act

  // Level 4 on SP high, then output low; level 1 stays quiet at PV 50
  task automatic t_lvl4;
    wr(8'h23, 16'h0064);
    wr(8'h07, 16'h0029);
    @(posedge clk_in);
    sp_in <= 16'h0096;
    cyc(3);
    chk("sp high status", {12'h000, status_out}, 16'h0008);
    chk("sp high relay", {12'h000, relay_out}, 16'h0008);
    rdc("status word", 8'h02, 16'h0088, 16'h00ff);
    wr(8'h07, 16'h0035);
    @(posedge clk_in);
    mv_in <= 16'h00c8;
    cyc(3);
    chk("out low clear", {12'h000, status_out}, 16'h0000);
    @(posedge clk_in);
    mv_in <= 16'h0064;
    cyc(3);
    chk("out low set", {12'h000, status_out}, 16'h0008);
    wr(8'h07, 16'h0020);
    cyc(2);
    chk("level 4 off", {12'h000, status_out}, 16'h0000);
  endtask : t_lvl4

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_range();
    t_hys();
    t_grp();
    t_sb();
    t_dly();
    t_act();
    t_lvl4();
    close_out();
  end
endmodule : testbench
`default_nettype wire
